// file: src/uog_global_ctrl.sv
// global control, soft reset sequencing and interrupt flags with ahb-lite slave
`timescale 1ns/100ps
module uog_global_ctrl
    import uog_pkg::*;
#(
    parameter int SUSP_IDLE_CYC = SUSP_IDLE_CYC_DEF
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic ID_PIN,
    input wire logic VBUS_VALID,
    input wire uog_evt_t EVT,
    input wire uog_lvl_t LVL,
    output logic HOST_MODE,
    output logic SUSPENDED,
    output logic [3:0] TURNAROUND,
    output logic [7:0] TIMEOUT_CLKS,
    output logic ROLE_SWAP_EN,
    output logic SESSION_REQ_EN,
    output logic TX_FLUSH_REQ,
    output logic [3:0] TX_FLUSH_MASK,
    output logic RX_FLUSH_REQ,
    output logic FRAME_CNT_RST,
    output logic BUS_SRST,
    output logic CORE_SRST
);
    localparam int CNT_W = $clog2(SUSP_IDLE_CYC + 1);

    // ************************************************************
    // declarations
    // ************************************************************
    logic ap_q, ap_wr_q;
    logic [7:0] ap_addr_q;
    logic accept, wr_en;
    logic wr_ahb, wr_usb, wr_rst, wr_int;
    logic [31:0] ahb_q, usb_q;
    logic [4:0] fsel_q;
    logic txf_q, rxf_q, fcr_q, bus_q, core_q;
    logic [3:0] srst_cnt_q;
    logic [3:0] tx_mask_q;
    logic soft_wipe, fcr_fault;
    logic host_q, dev;
    logic id_s, id_prev_q, vbus_s, vbus_prev_q;
    logic oset_q, iset_q, global_out_nak_effective_q, ginak_q;
    logic [CNT_W-1:0] idle_cnt_q;
    logic susp_q, susp_hit;
    logic [31:0] set_v, clr_v, flag_q, int_rd, rst_rd, rd_d;
    logic [7:0] tmo_q;

    // ************************************************************
    // ahb-lite slave: one wait state on every transfer
    // ************************************************************
    assign accept = HSEL && HTRANS[1] && HREADY;
    assign wr_en = ap_q && ap_wr_q;
    assign wr_ahb = wr_en && (ap_addr_q == OFS_AHB_CTL);
    assign wr_usb = wr_en && (ap_addr_q == OFS_USB_CTL);
    assign wr_rst = wr_en && (ap_addr_q == OFS_RST_CTL);
    assign wr_int = wr_en && (ap_addr_q == OFS_INT_FLAG);

    // non-word sizes decode as unmapped, so they never touch a register
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ap_q <= 1'b0;
            ap_wr_q <= 1'b0;
            ap_addr_q <= 8'h00;
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
        end else if (CE) begin
            if (ap_q) begin
                ap_q <= 1'b0;
                HREADYOUT <= 1'b1;
            end else if (accept) begin
                ap_q <= 1'b1;
                ap_wr_q <= HWRITE;
                ap_addr_q <= (HSIZE == HSIZE_WORD && HADDR[31:8] == 24'h000000) ?
                    HADDR[7:0] : 8'hff;
                HREADYOUT <= 1'b0;
            end
        end
    end

    // read data loaded at the edge that ends the wait state
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            HRDATA <= 32'h0000_0000;
        end else if (CE && ap_q && !ap_wr_q) begin
            HRDATA <= rd_d;
        end
    end

    always_comb begin
        rst_rd = 32'h0000_0000;
        rst_rd[B_IDLE] = !(txf_q || rxf_q || fcr_q || bus_q || core_q);
        rst_rd[B_FSEL_LSB +: 5] = fsel_q;
        rst_rd[B_TXF] = txf_q;
        rst_rd[B_RXF] = rxf_q;
        rst_rd[B_FCR] = fcr_q;
        rst_rd[B_BSR] = bus_q;
        rst_rd[B_CSR] = core_q;
        case (ap_addr_q)
            OFS_AHB_CTL: rd_d = ahb_q;
            OFS_USB_CTL: rd_d = usb_q;
            OFS_RST_CTL: rd_d = rst_rd;
            OFS_INT_FLAG: rd_d = int_rd;
            default: rd_d = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    // reserved bits keep their reset value on every write
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            ahb_q <= AHB_CTL_RST;
            usb_q <= USB_CTL_RST;
        end else if (CE) begin
            if (wr_ahb) begin
                ahb_q <= (HWDATA & AHB_CTL_WMASK) | (AHB_CTL_RST & ~AHB_CTL_WMASK);
            end
            if (wr_usb) begin
                usb_q <= (HWDATA & USB_CTL_WMASK) | (USB_CTL_RST & ~USB_CTL_WMASK);
            end
        end
    end

    // role and timing trims; role and timeout outputs follow the register one cycle late, turnaround and enables at once
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            host_q <= 1'b0;
            tmo_q <= TIMEOUT_BASE_PHY;
        end else if (CE) begin
            host_q <= usb_q[B_FDM] ? 1'b0 : (usb_q[B_FHM] ? 1'b1 : !id_s);
            tmo_q <= TIMEOUT_BASE_PHY + {5'h00, usb_q[B_TOC_LSB +: 3]};
        end
    end
    assign dev = !host_q;
    assign HOST_MODE = host_q;
    assign TIMEOUT_CLKS = tmo_q;
    assign TURNAROUND = usb_q[B_UTT_LSB +: 4];
    assign ROLE_SWAP_EN = usb_q[B_ROLE_SWAP];
    assign SESSION_REQ_EN = usb_q[B_SESS_REQ];

    // ************************************************************
    // reset control: flushes, frame counter reset, soft resets
    // ************************************************************
    function automatic logic [3:0] flush_decode(input logic [4:0] sel, input logic host);
        logic [3:0] m;
        m = 4'h0;
        if (sel[4]) begin
            m = host ? HOST_ALL_TX : DEV_ALL_TX;
        end else if (host) begin
            if (sel == 5'h00) m = 4'h1;
            if (sel == 5'h01) m = 4'h2;
        end else if (sel[3:2] == 2'h0) begin
            m = 4'h1 << sel[1:0];
        end
        return m;
    endfunction

    assign soft_wipe = core_q || bus_q;
    assign fcr_fault = wr_rst && HWDATA[B_FCR] && !host_q;

    // a write later in the block wins over a completion in the same cycle
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            fsel_q <= 5'h00;
            txf_q <= 1'b0;
            rxf_q <= 1'b0;
            fcr_q <= 1'b0;
            bus_q <= 1'b0;
            core_q <= 1'b0;
            srst_cnt_q <= 4'h0;
            tx_mask_q <= 4'h0;
        end else if (CE) begin
            fcr_q <= 1'b0;
            if (soft_wipe) begin
                if (srst_cnt_q == 4'h0) begin
                    bus_q <= 1'b0;
                    core_q <= 1'b0;
                end else begin
                    srst_cnt_q <= srst_cnt_q - 4'h1;
                end
            end
            if (txf_q && EVT.tx_flush_done) txf_q <= 1'b0;
            if (rxf_q && EVT.rx_flush_done) rxf_q <= 1'b0;
            if (core_q) begin
                txf_q <= 1'b0;
                rxf_q <= 1'b0;
                fsel_q <= 5'h00;
            end
            if (wr_rst) begin
                fsel_q <= HWDATA[B_FSEL_LSB +: 5];
                if (HWDATA[B_TXF]) begin
                    txf_q <= 1'b1;
                    tx_mask_q <= flush_decode(HWDATA[B_FSEL_LSB +: 5], host_q);
                end
                if (HWDATA[B_RXF]) rxf_q <= 1'b1;
                if (HWDATA[B_FCR] && host_q) fcr_q <= 1'b1;
                if (HWDATA[B_BSR] || HWDATA[B_CSR]) srst_cnt_q <= SRST_CYC - 4'h1;
                if (HWDATA[B_BSR]) bus_q <= 1'b1;
                if (HWDATA[B_CSR]) core_q <= 1'b1;
            end
        end
    end
    assign TX_FLUSH_REQ = txf_q;
    assign TX_FLUSH_MASK = tx_mask_q;
    assign RX_FLUSH_REQ = rxf_q;
    assign FRAME_CNT_RST = fcr_q;
    assign BUS_SRST = bus_q;
    assign CORE_SRST = core_q;

    // ************************************************************
    // pin synchronisers and edge history
    // ************************************************************
    uog_sync2 #(.RST_VAL(1'b1)) u_id_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .d(ID_PIN),
        .q(id_s)
    );
    uog_sync2 #(.RST_VAL(1'b0)) u_vbus_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .d(VBUS_VALID),
        .q(vbus_s)
    );
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            id_prev_q <= 1'b1;
            vbus_prev_q <= 1'b0;
        end else if (CE) begin
            id_prev_q <= id_s;
            vbus_prev_q <= vbus_s;
        end
    end

    // ************************************************************
    // suspend detection and nak effective states
    // ************************************************************
    // a soft reset in progress wins, so suspend never starts under a wipe
    assign susp_hit = dev && LVL.bus_idle && !susp_q && !soft_wipe &&
        (idle_cnt_q == CNT_W'(SUSP_IDLE_CYC - 1));
    // any bus activity or a role change restarts the idle count
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            idle_cnt_q <= '0;
            susp_q <= 1'b0;
        end else if (CE) begin
            if (!dev || !LVL.bus_idle || soft_wipe) begin
                idle_cnt_q <= '0;
                susp_q <= 1'b0;
            end else if (susp_hit) begin
                susp_q <= 1'b1;
            end else if (!susp_q) begin
                idle_cnt_q <= idle_cnt_q + CNT_W'(1);
            end
        end
    end
    assign SUSPENDED = susp_q;

    // a request takes effect one cycle after it is seen
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            oset_q <= 1'b0;
            iset_q <= 1'b0;
            global_out_nak_effective_q <= 1'b0;
            ginak_q <= 1'b0;
        end else if (CE) begin
            oset_q <= dev && EVT.out_nak_set;
            iset_q <= dev && EVT.in_nak_set;
            if (soft_wipe) global_out_nak_effective_q <= 1'b0;
            else if (oset_q) global_out_nak_effective_q <= 1'b1;
            else if (EVT.out_nak_clr) global_out_nak_effective_q <= 1'b0;
            if (soft_wipe) ginak_q <= 1'b0;
            else if (iset_q) ginak_q <= 1'b1;
            else if (EVT.in_nak_clr) ginak_q <= 1'b0;
        end
    end

    // ************************************************************
    // interrupt flags; no enable gates a flag
    // ************************************************************
    always_comb begin
        set_v = 32'h0000_0000;
        set_v[F_WAKE] = dev ? EVT.resume_det : EVT.remote_wake;
        set_v[F_SESS] = !id_s ? EVT.srp_det : (vbus_s && !vbus_prev_q);
        set_v[F_DISC] = host_q && EVT.disconnect;
        set_v[F_IDCHG] = id_s != id_prev_q;
        set_v[F_PINC] = host_q ? (EVT.frame_end && LVL.per_incomplete) :
            (EVT.eopf_hit && LVL.iso_out_incomplete);
        set_v[F_IINC] = dev && EVT.eopf_hit && LVL.iso_in_incomplete;
        set_v[F_EOPF] = dev && EVT.eopf_hit;
        set_v[F_ISODROP] = dev && EVT.iso_drop;
        set_v[F_ENUM] = dev && EVT.enum_done;
        set_v[F_USBRST] = dev && EVT.usb_reset;
        set_v[F_SUSP] = susp_hit;
        set_v[F_ESUSP] = susp_hit;
        set_v[F_SOF] = EVT.sof;
        set_v[F_MFLT] = EVT.mode_fault || fcr_fault;
    end
    assign clr_v = wr_int ? (HWDATA & FLAG_W1C_MASK) : 32'h0000_0000;

    for (genvar i = 0; i < 32; i++) begin : g_flag
        if (FLAG_W1C_MASK[i]) begin : g_on
            uog_sticky_flag u_flag (
                .clk(CLK),
                .rst_n(RST_N),
                .ce(CE),
                .wipe(soft_wipe),
                .set(set_v[i]),
                .clr(clr_v[i]),
                .q(flag_q[i])
            );
        end else begin : g_off
            assign flag_q[i] = 1'b0;
        end
    end

    // level flags mirror their sources and cannot be cleared by writes
    always_comb begin
        int_rd = flag_q;
        int_rd[F_PTXE] = host_q &&
            (ahb_q[B_PTX_THR] ? LVL.ptx_empty : LVL.ptx_half);
        int_rd[F_NPTXE] = host_q && (ahb_q[B_TX_THR] ? LVL.nptx_empty : LVL.nptx_half);
        int_rd[F_HC] = host_q && LVL.hc_any;
        int_rd[F_HP] = host_q && LVL.hp_any;
        int_rd[F_OEP] = dev && LVL.oep_any;
        int_rd[F_IEP] = dev && LVL.iep_any;
        int_rd[F_OTG] = LVL.otg_any;
        int_rd[F_GLOBAL_OUT_NAK_EFFECTIVE] = global_out_nak_effective_q;
        int_rd[F_GINAK] = ginak_q;
        int_rd[F_RXNE] = LVL.rx_nonempty;
        int_rd[F_ROLE] = host_q;
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N || !CE);

    sequence s_srst_start;
        $rose(core_q);
    endsequence
    sequence s_srst_end;
        ##[1:10] !core_q && !bus_q;
    endsequence

    a_force_dev_role: assert property (CE && usb_q[B_FDM] |=> !host_q)
        else $error("forced device role not taken");
    a_wake_sets_flag: assert property (CE && set_v[F_WAKE] && !soft_wipe
        |=> flag_q[F_WAKE])
        else $error("wakeup event lost");
    a_write_zero_keeps: assert property (CE && wr_int && !HWDATA[F_SOF] && flag_q[F_SOF]
        && !soft_wipe |=> flag_q[F_SOF])
        else $error("flag cleared by writing zero");
    a_frame_rst_pulse: assert property (CE && fcr_q |=> !fcr_q)
        else $error("frame counter reset did not self-clear");
    a_mode_fault_set: assert property (CE && fcr_fault && !soft_wipe
        |=> flag_q[F_MFLT] && !fcr_q)
        else $error("device-mode frame reset not faulted");
    a_suspend_flags: assert property (CE && susp_hit |=> susp_q && flag_q[F_SUSP]
        && flag_q[F_ESUSP])
        else $error("suspend flags missing");
    a_soft_rst_ends: assert property (s_srst_start |-> s_srst_end)
        else $error("core soft reset did not finish");
    a_nak_effect: assert property (CE && dev && EVT.out_nak_set && !soft_wipe
        ##1 CE && !soft_wipe |=> global_out_nak_effective_q)
        else $error("out nak effective not set");
    a_flush_done_clr: assert property (CE && txf_q && EVT.tx_flush_done && !wr_rst
        |=> !txf_q)
        else $error("tx flush bit not cleared");
    a_ptx_threshold: assert property (host_q && ahb_q[B_PTX_THR] && !LVL.ptx_empty
        |-> !int_rd[F_PTXE])
        else $error("periodic empty flag ignores threshold");
endmodule

// file: src/uog_pkg.sv
// package for the usb otg core global control and interrupt flag block
// Operation
// - force bits override the identification pin role
// - turnaround field gives turnaround in phy clocks
// - bits 9 and 8 enable role-swap, session-request
// - timeout is standard plus calibration phy clocks
// - flush select chooses which transmit fifo flushes
// - flush bits self-clear when flush completes
// - host frame counter reset pulses, then self-clears
// - bus clock soft reset self-clears when finished
// - core soft reset clears both domains and flags
// - wakeup flag on resume or remote wakeup
// - session flag on request or bus power valid
// - transmit empty flags follow threshold in host mode
// - summary flags read-only, follow their sources
// - incomplete periodic or isochronous flags at frame end
// - periodic frame end flag at threshold time
// - dropped isochronous out packet sets flag
// - 3 ms idle sets early suspend and suspend
// - nak request taking effect sets effective flag
// - receive fifo non-empty flag follows fifo contents
// - wrong-mode access ignored and sets mode fault
// - bit 0 reports current role, 1 host
// - flags set regardless of any interrupt enable
// - periodic threshold: 0 half, 1 completely empty
package uog_pkg;
    // ************************************************************
    // register offsets and reset values
    // ************************************************************
    localparam logic [7:0] OFS_AHB_CTL = 8'h08;
    localparam logic [7:0] OFS_USB_CTL = 8'h0c;
    localparam logic [7:0] OFS_RST_CTL = 8'h10;
    localparam logic [7:0] OFS_INT_FLAG = 8'h14;
    localparam logic [31:0] AHB_CTL_RST = 32'h0000_0000;
    localparam logic [31:0] AHB_CTL_WMASK = 32'h0000_0181;
    localparam logic [31:0] USB_CTL_RST = 32'h0000_0a80;
    localparam logic [31:0] USB_CTL_WMASK = 32'h6000_3f07;
    localparam logic [31:0] RST_CTL_RST = 32'h8000_0000;
    localparam logic [31:0] INT_FLAG_RST = 32'h0400_0021;
    localparam logic [31:0] FLAG_W1C_MASK = 32'hf030_fc0a;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int B_PTX_THR = 8;
    localparam int B_TX_THR = 7;
    localparam int B_FDM = 30;
    localparam int B_FHM = 29;
    localparam int B_UTT_LSB = 10;
    localparam int B_ROLE_SWAP = 9;
    localparam int B_SESS_REQ = 8;
    localparam int B_TOC_LSB = 0;
    localparam int B_IDLE = 31;
    localparam int B_FSEL_LSB = 6;
    localparam int B_TXF = 5;
    localparam int B_RXF = 4;
    localparam int B_FCR = 2;
    localparam int B_BSR = 1;
    localparam int B_CSR = 0;
    localparam int F_WAKE = 31;
    localparam int F_SESS = 30;
    localparam int F_DISC = 29;
    localparam int F_IDCHG = 28;
    localparam int F_PTXE = 26;
    localparam int F_HC = 25;
    localparam int F_HP = 24;
    localparam int F_PINC = 21;
    localparam int F_IINC = 20;
    localparam int F_OEP = 19;
    localparam int F_IEP = 18;
    localparam int F_EOPF = 15;
    localparam int F_ISODROP = 14;
    localparam int F_ENUM = 13;
    localparam int F_USBRST = 12;
    localparam int F_SUSP = 11;
    localparam int F_ESUSP = 10;
    localparam int F_GLOBAL_OUT_NAK_EFFECTIVE = 7;
    localparam int F_GINAK = 6;
    localparam int F_NPTXE = 5;
    localparam int F_RXNE = 4;
    localparam int F_SOF = 3;
    localparam int F_OTG = 2;
    localparam int F_MFLT = 1;
    localparam int F_ROLE = 0;
    localparam logic [3:0] HOST_ALL_TX = 4'h3;
    localparam logic [3:0] DEV_ALL_TX = 4'hf;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int SUSP_IDLE_US = 3000;
    localparam int SUSP_IDLE_CYC_DEF = SUSP_IDLE_US * (CLK_HZ / 1_000_000);
    localparam logic [3:0] SRST_CYC = 4'h8;
    localparam logic [7:0] TIMEOUT_BASE_PHY = 8'h48;
    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic resume_det;
        logic remote_wake;
        logic srp_det;
        logic disconnect;
        logic enum_done;
        logic usb_reset;
        logic sof;
        logic iso_drop;
        logic frame_end;
        logic eopf_hit;
        logic out_nak_set;
        logic out_nak_clr;
        logic in_nak_set;
        logic in_nak_clr;
        logic mode_fault;
        logic tx_flush_done;
        logic rx_flush_done;
    } uog_evt_t;
    typedef struct packed {
        logic per_incomplete;
        logic iso_out_incomplete;
        logic iso_in_incomplete;
        logic ptx_half;
        logic ptx_empty;
        logic nptx_half;
        logic nptx_empty;
        logic rx_nonempty;
        logic hc_any;
        logic hp_any;
        logic oep_any;
        logic iep_any;
        logic otg_any;
        logic bus_idle;
    } uog_lvl_t;
endpackage

// file: src/uog_sync2.sv
// two-stage synchroniser for pin levels
`timescale 1ns/100ps
module uog_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic d,
    output logic q
);
    logic meta_q;
    // first stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            q <= RST_VAL;
        end else if (ce) begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule

// file: src/uog_sticky_flag.sv
// one sticky event flag, set by hardware and cleared by writing one
`timescale 1ns/100ps
module uog_sticky_flag (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic wipe,
    input wire logic set,
    input wire logic clr,
    output logic q
);
    // set beats a same-cycle clear so no event is lost; soft reset beats both
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            q <= 1'b0;
        end else if (ce) begin
            if (wipe) begin
                q <= 1'b0;
            end else if (set) begin
                q <= 1'b1;
            end else if (clr) begin
                q <= 1'b0;
            end
        end
    end
endmodule

// file: sim/uog_far_end.sv
// cable-side partner model: events, levels, id pin and vbus
`timescale 1ns/100ps
module uog_far_end
    import uog_pkg::*;
(
    input wire logic clk,
    output uog_evt_t evt,
    output uog_lvl_t lvl,
    output logic id_pin,
    output logic vbus
);
    // idle cable: b-device, no power, no events
    initial begin
        evt = '0;
        lvl = '0;
        id_pin = 1'b1;
        vbus = 1'b0;
    end
    // one-cycle burst, launched after an edge so it is sampled once
    task automatic pulse(input uog_evt_t m);
        evt <= m;
        @(posedge clk);
        evt <= '0;
    endtask
endmodule

// file: sim/tb.sv
// self-checking bench for the global control and flag block
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module tb
    import uog_pkg::*;
;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic HSEL = 1'b0;
    logic HWRITE = 1'b0;
    logic [1:0] HTRANS = 2'h0;
    logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA, r, v;
    logic HREADYOUT, HRESP, HOST_MODE, SUSPENDED, ROLE_SWAP_EN, SESSION_REQ_EN;
    logic TX_FLUSH_REQ, RX_FLUSH_REQ, FRAME_CNT_RST, BUS_SRST, CORE_SRST, ID_PIN, VBUS_VALID;
    logic [3:0] TURNAROUND, TX_FLUSH_MASK;
    logic [7:0] TIMEOUT_CLKS;
    uog_evt_t EVT;
    uog_lvl_t LVL;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    int pulses = 0;
    logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h03, 5'h04, 5'h10, 5'h1b};
    // ****************************************
    // design, partner and bus helpers
    // ****************************************
    uog_global_ctrl #(.SUSP_IDLE_CYC(20)) DUT (.CLK, .RST_N, .CE(1'b1), .HSEL, .HADDR,
        .HTRANS, .HWRITE, .HSIZE(HSIZE_WORD), .HWDATA, .HREADY(HREADYOUT), .HRDATA,
        .HREADYOUT, .HRESP, .ID_PIN, .VBUS_VALID, .EVT, .LVL, .HOST_MODE, .SUSPENDED,
        .TURNAROUND, .TIMEOUT_CLKS, .ROLE_SWAP_EN, .SESSION_REQ_EN, .TX_FLUSH_REQ,
        .TX_FLUSH_MASK, .RX_FLUSH_REQ, .FRAME_CNT_RST, .BUS_SRST, .CORE_SRST);
    uog_far_end far (.clk(CLK), .evt(EVT), .lvl(LVL), .id_pin(ID_PIN), .vbus(VBUS_VALID));
    initial begin
        forever #20 CLK = ~CLK;
    end
    // frame counter reset pulses, counted mid-cycle where the output is settled
    always @(negedge CLK) begin
        if (FRAME_CNT_RST === 1'b1) pulses <= pulses + 1;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            err_count++;
            print_verdict();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // device-mode flush mask: one fifo, all of them, or none
    function automatic logic [3:0] fmask(input logic [4:0] c);
        if (c[4]) return DEV_ALL_TX;
        return (c < 5'h4) ? 4'h1 << c[1:0] : 4'h0;
    endfunction
    // host level flags {26,25,24,19,18,5,4,2,0}: thresholds s[15:14], levels s[13:1]
    function automatic logic [8:0] hostlv(input logic [31:0] s);
        return {s[15] ? s[9] : s[10], s[5], s[4], 2'h0, s[14] ? s[7] : s[8], s[6], s[1], 1'b1};
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge CLK);
    endtask
    // one single word transfer; address held until ready, data taken at its end
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= w;
        HADDR <= {24'h0, a};
        tick(1);
        while (HREADYOUT !== 1'b1) tick(1);
        HSEL <= 1'b0;
        HTRANS <= 2'h0;
        HWDATA <= d;
        tick(1);
        while (HREADYOUT !== 1'b1) tick(1);
        r = HRDATA;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        v = 32'h60e7;
        tick(16);
        RST_N <= 1'b1;
        tick(1);
        bus(0, OFS_USB_CTL, 0);
        `CHK(r, USB_CTL_RST)
        for (int i = 0; i < 8; i++) begin
            v = lfsr(v);
            bus(1, OFS_USB_CTL, v & 32'h0000_3f07);
            tick(1);
            `CHK(TURNAROUND, v[13:10])
            `CHK({ROLE_SWAP_EN, SESSION_REQ_EN}, v[9:8])
            `CHK(TIMEOUT_CLKS, TIMEOUT_BASE_PHY + {5'h0, v[2:0]})
        end
        $display("trim fields done");
        foreach (codes[i]) begin
            bus(1, OFS_RST_CTL, {21'h0, codes[i], 6'h30});
            tick(1);
            `CHK({TX_FLUSH_REQ, RX_FLUSH_REQ, TX_FLUSH_MASK}, {2'h3, fmask(codes[i])})
            far.pulse(17'h3);
            bus(0, OFS_RST_CTL, 0); // software reads back once after the completion pulse
            `CHK(r, {1'b1, 20'h0, codes[i], 6'h0})
        end
        $display("flush done");
        far.vbus <= 1'b1;
        far.lvl.iso_in_incomplete <= 1'b1;
        far.pulse(17'h6d0);
        tick(3);
        bus(0, OFS_INT_FLAG, 0);
        `CHK({r[31:28], r[7:3]}, 9'h099)
        `CHK({r[21:20], r[15:14]}, 4'h7)
        bus(1, OFS_INT_FLAG, 0);
        bus(0, OFS_INT_FLAG, 0);
        `CHK(r[3], 1'b1)
        bus(1, OFS_INT_FLAG, 32'h8);
        bus(0, OFS_INT_FLAG, 0);
        `CHK(r[3], 1'b0)
        bus(1, OFS_RST_CTL, 32'h4);
        far.lvl.bus_idle <= 1'b1;
        tick(24);
        bus(0, OFS_INT_FLAG, 0);
        `CHK({r[11:10], r[1], SUSPENDED}, 4'hf)
        far.lvl.bus_idle <= 1'b0;
        $display("flags done");
        bus(1, OFS_RST_CTL, 32'h2);
        tick(1);
        `CHK(BUS_SRST, 1'b1)
        do bus(0, OFS_RST_CTL, 0); while (r[1] !== 1'b0);
        bus(1, OFS_RST_CTL, 32'h7c1);
        tick(1);
        `CHK(CORE_SRST, 1'b1)
        do bus(0, OFS_RST_CTL, 0); while (r[0] !== 1'b0);
        `CHK(r, RST_CTL_RST)
        bus(0, OFS_INT_FLAG, 0);
        `CHK(r & FLAG_W1C_MASK, 32'h0)
        $display("soft reset done");
        far.id_pin <= 1'b0;
        bus(1, OFS_USB_CTL, 32'h4000_0000);
        tick(4); // role settle wait, scaled down like the idle time
        `CHK(HOST_MODE, 1'b0)
        bus(1, OFS_USB_CTL, 32'h0);
        tick(4);
        bus(0, OFS_INT_FLAG, 0);
        `CHK({HOST_MODE, r[0]}, 2'h3)
        $display("role done");
        for (int i = 0; i < 4; i++) begin
            v = lfsr(v);
            if (i == 0) v[15:9] = 7'h42; // half empty under empty threshold
            bus(1, OFS_AHB_CTL, {23'h0, v[15:14], 7'h0});
            far.lvl <= {v[13:1], 1'b0};
            tick(1);
            bus(0, OFS_INT_FLAG, 0);
            `CHK({r[26:24], r[19:18], r[5:4], r[2], r[0]}, hostlv(v))
        end
        bus(1, OFS_RST_CTL, 32'h60);
        tick(1);
        `CHK(TX_FLUSH_MASK, 4'h2)
        far.pulse(17'h8002);
        bus(1, OFS_RST_CTL, 32'h4);
        bus(0, OFS_INT_FLAG, 0);
        `CHK({pulses == 1, r[31], r[1], HRESP, TX_FLUSH_REQ}, 5'h18)
        $display("host done");
        print_verdict();
    end
endmodule
